// >>> hdl/szts_sram.sv
// zero-turnaround flow-through static memory with its write posting buffer
`include "szts_map.svh"

// ------------------------------------------------------------
// posting buffer
// ------------------------------------------------------------
module szts_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SZTS_FIFO_DEPTH,
    parameter int PW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [DEPTH*WIDTH-1:0] peek,
    output logic [PW-1:0] head,
    output logic [PW:0] count
);
    logic [WIDTH-1:0] slot [DEPTH];
    logic [PW-1:0] head_ff;
    logic [PW-1:0] tail_ff;
    logic [PW:0] count_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_ff != (PW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = slot[head_ff];
    assign head = head_ff;
    assign count = count_ff;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            peek[i*WIDTH +: WIDTH] = slot[i];
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            slot[tail_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            head_ff <= '0;
            tail_ff <= '0;
            count_ff <= '0;
        end else begin
            head_ff <= pop ? PW'(head_ff + 1'b1) : head_ff;
            tail_ff <= push ? PW'(tail_ff + 1'b1) : tail_ff;
            count_ff <= (PW+1)'(count_ff + (PW+1)'(push) - (PW+1)'(pop));
        end
    end
endmodule

// Overview of operation
// (RL1) all synchronous inputs are captured on the rising clock edge
// (RL2) data moves one cycle after its address and control were sampled
// (RL3) reads and writes alternate back to back with no idle cycle
// (RL4) edges with clock suspend sampled high ignore every synchronous input
// (RL5) while suspended every internal register keeps its contents; here the posting buffer, pin synchronizers and status flags still move
// (RL6) inactive select with a load starts nothing and ends any burst
// (RL7) a deselect still completes the data phase already pending
// (RL8) bus floats one cycle after a deselect or a write access begins
// (RL9) a two-bit counter gives four beats from one supplied address
// (RL10) burst order input picks linear or interleaved beat sequence
// (RL11) load low takes a new address, load high steps the counter
// (RL12) output drive, sleep and burst order act without the clock; here sleep and burst order pass a clocked synchronizer
// (RL13) a system without sleep holds the sleep request low
// (RL14) low power entered on sleep request or when deselected
// (RL15) array holds 262144 words of 36 bits or 524288 of 18
// (RL16) each lane has its own active low write control
// (RL17) a lane is written only if its control was low at sampling
// (RL18) direction sampled with a load holds for all its burst beats
// (RL19) the two lowest address bits seed the burst counter
// (RL20) second select is active high, first and third active low
// (RL21) linear adds beat modulo four, interleaved xors beat with start
module szts_sram #(
    parameter int ADDR_W = `SZTS_WIDE_ADDR_W,
    parameter int DATA_W = `SZTS_WIDE_DATA_W,
    parameter int DEPTH = `SZTS_FIFO_DEPTH,
    parameter int LANES = DATA_W / `SZTS_LANE_W
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] DQ_IN,
    output logic [DATA_W-1:0] DQ_OUT,
    output logic DQ_OE,
    input wire logic [LANES-1:0] LANE_WRITE_N,
    input wire logic WRITE_SELECT_N,
    input wire logic ADVANCE_OR_LOAD,
    input wire logic CLOCK_SUSPEND_N,
    input wire logic SELECT_FIRST_N_ALT,
    input wire logic SELECT_SECOND,
    input wire logic SELECT_THIRD_N,
    input wire logic SLEEP_REQUEST,
    input wire logic BURST_ORDER,
    input wire logic OUTPUT_DRIVE_N,
    output logic LOW_POWER,
    output logic WRITE_ROOM
);
    localparam int LW = `SZTS_LANE_W;
    localparam int ENT_W = ADDR_W + LANES + DATA_W;
    localparam int PW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] beat,
                                             input szts_pkg::szts_order_t order);
        if (order == szts_pkg::SZTS_INTERLEAVED) begin
            burst_low = start ^ beat; // see (RL21)
        end else begin
            burst_low = 2'(start + beat);
        end
    endfunction

    function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_word,
                                                     input logic [DATA_W-1:0] new_word,
                                                     input logic [LANES-1:0] lanes_n);
        logic [DATA_W-1:0] r;
        r = old_word;
        for (int l = 0; l < LANES; l++) begin
            if (!lanes_n[l]) begin
                r[l*LW +: LW] = new_word[l*LW +: LW];
            end
        end
        lane_merge = r;
    endfunction

    // ------------------------------------------------------------
    // asynchronous pins: three stages, change taken when last two agree
    // ------------------------------------------------------------
    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;
    logic [1:0] sync3_ff;
    logic [1:0] pin_ff;
    wire logic [1:0] nxt_pin = (sync2_ff == sync3_ff) ? sync3_ff : pin_ff;
    wire logic sleep_now = pin_ff[0];
    wire szts_pkg::szts_order_t order_now = szts_pkg::szts_order_t'(pin_ff[1]);

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            pin_ff <= '0;
        end else begin
            sync1_ff <= {BURST_ORDER, SLEEP_REQUEST}; // see (RL12)
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            pin_ff <= nxt_pin;
        end
    end

    // ------------------------------------------------------------
    // cycle decode
    // ------------------------------------------------------------
    logic active_ff;
    logic dir_write_ff;
    logic [ADDR_W-1:0] base_ff;
    logic [1:0] start_ff;
    logic [1:0] cnt_ff;
    logic ph_valid_ff;
    logic ph_write_ff;
    logic [ADDR_W-1:0] ph_addr_ff;
    logic [LANES-1:0] ph_lanes_ff;
    logic desel_ff;
    logic drive_ff;
    logic [DATA_W-1:0] dq_out_ff;
    logic low_power_ff;
    logic room_ff;

    // suspended edges leave the burst, data phase and read data output registers as they were
    wire logic go = !CLOCK_SUSPEND_N; // see (RL4)
    // sleep acts as a fourth select term
    wire logic selected = !SELECT_FIRST_N_ALT && SELECT_SECOND && !SELECT_THIRD_N
        && !sleep_now; // see (RL20)
    wire logic load = go && !ADVANCE_OR_LOAD && selected; // see (RL11)
    wire logic deselect = go && !ADVANCE_OR_LOAD && !selected; // see (RL6)
    wire logic step = go && ADVANCE_OR_LOAD && active_ff; // see (RL11)
    wire logic access = load || step;
    wire logic acc_write = load ? !WRITE_SELECT_N : dir_write_ff; // see (RL18)
    wire logic [1:0] nxt_cnt = load ? `SZTS_BURST_FIRST
        : 2'(cnt_ff + `SZTS_BURST_STEP); // see (RL9)
    wire logic [1:0] step_low = burst_low(start_ff, nxt_cnt, order_now); // see (RL10)
    wire logic [ADDR_W-1:0] nxt_addr = load ? ADDR : {base_ff[ADDR_W-1:2], step_low};

    // ------------------------------------------------------------
    // storage and posted writes
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [2**ADDR_W]; // see (RL15)
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [ENT_W-1:0] fifo_out;
    logic [DEPTH*ENT_W-1:0] fifo_peek;
    logic [PW-1:0] fifo_head;
    logic [PW:0] fifo_count;
    // write data arrives on the edge after its address was taken
    wire logic push = go && ph_valid_ff && ph_write_ff; // see (RL2) (RL7)
    // array writes wait while asleep; the buffer absorbs them meanwhile
    wire logic drain = !sleep_now;
    wire logic [ADDR_W-1:0] drain_addr = fifo_out[ENT_W-1 -: ADDR_W];
    wire logic [LANES-1:0] drain_lanes = fifo_out[DATA_W +: LANES];
    wire logic [DATA_W-1:0] drain_data = fifo_out[DATA_W-1:0];

    szts_fifo #(.WIDTH(ENT_W), .DEPTH(DEPTH)) u_post (
        .clk(SYS_CLK),
        .rst(RST),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data({ph_addr_ff, ph_lanes_ff, DQ_IN}),
        .out_valid(fifo_out_valid),
        .out_ready(drain),
        .out_data(fifo_out),
        .peek(fifo_peek),
        .head(fifo_head),
        .count(fifo_count)
    );

    always_ff @(posedge SYS_CLK) begin
        if (fifo_out_valid && drain) begin
            mem[drain_addr] <= lane_merge(mem[drain_addr], drain_data, drain_lanes); // see (RL17)
        end
    end

    // reads see every write still queued, oldest first, then the one arriving now
    logic [DATA_W-1:0] read_word;
    always_comb begin
        logic [ENT_W-1:0] ent;
        logic [PW-1:0] idx;
        ent = '0;
        idx = '0;
        read_word = mem[nxt_addr];
        for (int i = 0; i < DEPTH; i++) begin
            idx = PW'(fifo_head + PW'(i));
            ent = fifo_peek[idx*ENT_W +: ENT_W];
            if ((PW+1)'(i) < fifo_count && ent[ENT_W-1 -: ADDR_W] == nxt_addr) begin
                read_word = lane_merge(read_word, ent[DATA_W-1:0], ent[DATA_W +: LANES]);
            end
        end
        if (push && fifo_in_ready && ph_addr_ff == nxt_addr) begin
            read_word = lane_merge(read_word, DQ_IN, ph_lanes_ff); // see (RL3)
        end
    end

    // ------------------------------------------------------------
    // burst and data phase state
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            active_ff <= `SZTS_RST_BIT;
            dir_write_ff <= `SZTS_RST_BIT;
            base_ff <= '0;
            start_ff <= '0;
            cnt_ff <= '0;
            desel_ff <= `SZTS_RST_BIT;
        end else if (go) begin // see (RL5)
            active_ff <= access; // see (RL6)
            dir_write_ff <= acc_write;
            base_ff <= load ? ADDR : base_ff; // see (RL1)
            start_ff <= load ? ADDR[1:0] : start_ff; // see (RL19)
            cnt_ff <= access ? nxt_cnt : cnt_ff;
            desel_ff <= deselect ? 1'b1 : (load ? 1'b0 : desel_ff);
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ph_valid_ff <= `SZTS_RST_BIT;
            ph_write_ff <= `SZTS_RST_BIT;
            ph_addr_ff <= '0;
            ph_lanes_ff <= '1;
        end else if (go) begin
            ph_valid_ff <= access;
            ph_write_ff <= access && acc_write;
            ph_addr_ff <= nxt_addr;
            ph_lanes_ff <= LANE_WRITE_N; // see (RL16) (RL17)
        end
    end

    // read data is loaded on the edge that takes the address: flow-through
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            drive_ff <= `SZTS_RST_BIT;
            dq_out_ff <= '0;
        end else if (go) begin
            drive_ff <= access && !acc_write; // see (RL8)
            dq_out_ff <= (access && !acc_write) ? read_word : dq_out_ff; // see (RL2)
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            low_power_ff <= `SZTS_RST_LOW_POWER;
            room_ff <= `SZTS_RST_ROOM;
        end else begin
            low_power_ff <= sleep_now || (desel_ff && !ph_valid_ff); // see (RL14)
            room_ff <= fifo_in_ready;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign DQ_OUT = dq_out_ff;
    // the drive control gates the enable with no clock in the path
    assign DQ_OE = drive_ff && !OUTPUT_DRIVE_N; // see (RL12)
    assign LOW_POWER = low_power_ff;
    assign WRITE_ROOM = room_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    sequence s_write_taken;
        go && access && acc_write;
    endsequence

    // a data edge pushed back by suspension is held by a_suspend_holds
    sequence s_write_data;
        go ##0 push;
    endsequence

    a_suspend_holds: assert property (!go // see (RL4) (RL5)
        |=> $stable(base_ff) && $stable(cnt_ff) && $stable(ph_valid_ff) && $stable(dq_out_ff))
        else $error("state moved on a suspended edge");
    a_read_drives: assert property (go && access && !acc_write // see (RL2) (RL3)
        |=> drive_ff && ph_valid_ff && !ph_write_ff)
        else $error("read data phase missing");
    a_float_after_write: assert property (go && (deselect || (access && acc_write)) // see (RL8)
        |=> !DQ_OE)
        else $error("bus driven after write or deselect");
    a_deselect_ends_burst: assert property (deselect // see (RL6)
        |=> !active_ff ##0 !ph_valid_ff)
        else $error("burst survived a deselect");
    a_write_completes: assert property (s_write_taken ##1 go |-> push) // see (RL7)
        else $error("pending write not completed");
    a_step_counts: assert property (step // see (RL9) (RL18)
        |=> cnt_ff == 2'($past(cnt_ff) + 2'h1) && ph_write_ff == $past(dir_write_ff))
        else $error("burst step wrong");
    a_load_seeds: assert property (load // see (RL19) (RL11)
        |=> start_ff == $past(ADDR[1:0]) && cnt_ff == 2'h0 && ph_addr_ff == $past(ADDR))
        else $error("load did not seed burst");
    a_beat_address: assert property (step // see (RL21) (RL10)
        && order_now == szts_pkg::SZTS_INTERLEAVED
        |-> nxt_addr[1:0] == (start_ff ^ 2'(cnt_ff + 2'h1)))
        else $error("interleaved beat address wrong");
    a_drive_gated: assert property (OUTPUT_DRIVE_N |-> !DQ_OE) // see (RL12)
        else $error("outputs driven while drive disabled");
    a_sleep_power: assert property (sleep_now |=> LOW_POWER) // see (RL14)
        else $error("sleep did not lower power");
    a_lane_posted: assert property (s_write_taken ##1 s_write_data // see (RL17)
        |-> fifo_in_ready || !WRITE_ROOM || !$past(room_ff))
        else $error("write lost with room signalled");
endmodule

// >>> hdl/szts_map.svh
// offsets, widths, reset values and counts for the zero-turnaround static memory
`ifndef SZTS_MAP_SVH
`define SZTS_MAP_SVH

// ------------------------------------------------------------
// geometry
// ------------------------------------------------------------
`define SZTS_WIDE_ADDR_W 18
`define SZTS_WIDE_DATA_W 36
`define SZTS_WIDE_WORDS 262144
`define SZTS_NARROW_ADDR_W 19
`define SZTS_NARROW_DATA_W 18
`define SZTS_NARROW_WORDS 524288
`define SZTS_LANE_W 9

// ------------------------------------------------------------
// burst and buffering
// ------------------------------------------------------------
`define SZTS_BURST_CNT_W 2
`define SZTS_BURST_STEP 2'h1
`define SZTS_BURST_FIRST 2'h0
`define SZTS_FIFO_DEPTH 8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SZTS_RST_BIT 1'h0
`define SZTS_RST_LOW_POWER 1'h1
`define SZTS_RST_ROOM 1'h1

`endif

// >>> hdl/szts_pkg.sv
// types shared by the zero-turnaround static memory
package szts_pkg;

    // burst sequence selected by the burst order pin
    typedef enum logic {
        SZTS_LINEAR = 1'h0,
        SZTS_INTERLEAVED = 1'h1
    } szts_order_t;

endpackage

// >>> verification/szts_master.sv
// bus master model driving every input pin of the static memory except the clock and reset
module szts_master (
    input wire logic clk,
    output logic [17:0] addr,
    output logic [35:0] dq,
    output logic [3:0] lanes_n,
    output logic wsel_n,
    output logic adv,
    output logic susp_n,
    output logic [2:0] sel,
    output logic sleep,
    output logic order,
    output logic drive_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        addr = 18'h0;
        dq = 36'h0;
        lanes_n = 4'hF;
        wsel_n = 1'h1;
        adv = 1'h0;
        susp_n = 1'h0;
        sel = 3'h0;
        sleep = 1'h0;
        order = 1'h0;
        drive_n = 1'h0;
    end

    // ------------------------------------------------------------
    // one bus cycle, launched just after the rising edge
    // ------------------------------------------------------------
    task automatic cycle(input logic [17:0] a, input logic w_n, input logic ad,
            input logic s_n, input logic [2:0] se, input logic [3:0] ln, input logic dv,
            input logic [35:0] d, input logic slp, input logic ord, input logic dn);
        @(posedge clk);
        addr <= a;
        wsel_n <= w_n;
        adv <= ad;
        susp_n <= s_n;
        sel <= se;
        lanes_n <= ln;
        // a released data bus shows the inverse, never a stale match
        dq <= dv ? d : ~dq;
        sleep <= slp;
        order <= ord;
        drive_n <= dn;
    endtask
endmodule

// >>> verification/test_sync_flowthru_zero_turnaround_sram.sv
// self-checking bench for the zero-turnaround static memory
module test_sync_flowthru_zero_turnaround_sram;
    timeunit 1ns;
    timeprecision 1ps;

    logic SYS_CLK = 1'h0;
    logic RST = 1'h1;
    wire logic [17:0] addr;
    wire logic [35:0] dq_in;
    wire logic [3:0] lanes_n;
    wire logic [2:0] sel;
    wire logic wsel_n, adv, susp_n, sleep, order, drive_n;
    logic [35:0] dq_out;
    logic dq_oe, low_power, write_room;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [35:0] mem [int];
    logic [17:0] base = 18'h0;
    logic [17:0] paddr = 18'h0;
    logic [1:0] beat = 2'h0;
    logic [3:0] plns = 4'hF;
    logic [35:0] pdata = 36'h0;
    logic [35:0] exp_dq = 36'h0;
    logic bact = 1'h0, bw = 1'h0, wpend = 1'h0, exp_oe = 1'h0;
    logic slp = 1'h0, ord = 1'h0, dn = 1'h0;
    logic [2:0] sels [4] = '{3'h2, 3'h6, 3'h0, 3'h3};

    szts_master m_u (.clk(SYS_CLK), .addr(addr), .dq(dq_in), .lanes_n(lanes_n),
        .wsel_n(wsel_n), .adv(adv), .susp_n(susp_n), .sel(sel), .sleep(sleep),
        .order(order), .drive_n(drive_n));

    szts_sram dut_u (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(addr), .DQ_IN(dq_in),
        .DQ_OUT(dq_out), .DQ_OE(dq_oe), .LANE_WRITE_N(lanes_n), .WRITE_SELECT_N(wsel_n),
        .ADVANCE_OR_LOAD(adv), .CLOCK_SUSPEND_N(susp_n), .SELECT_FIRST_N_ALT(sel[2]),
        .SELECT_SECOND(sel[1]), .SELECT_THIRD_N(sel[0]), .SLEEP_REQUEST(sleep),
        .BURST_ORDER(order), .OUTPUT_DRIVE_N(drive_n), .LOW_POWER(low_power),
        .WRITE_ROOM(write_room));

    initial begin
        forever #25 SYS_CLK = ~SYS_CLK;
    end

    // ------------------------------------------------------------
    // checking and reference model
    // ------------------------------------------------------------
    task automatic end_sim;
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] d,
            input logic [3:0] ln);
        logic [35:0] r;
        r = old;
        for (int l = 0; l < 4; l++) begin
            if (!ln[l]) begin
                r[9*l +: 9] = d[9*l +: 9];
            end
        end
        return r;
    endfunction

    function automatic logic [35:0] rnd;
        logic [63:0] r;
        r = {$urandom(), $urandom()};
        return r[35:0];
    endfunction

    // only preloaded places: 0..15 and the top four words
    function automatic logic [17:0] pa(input int i);
        return i < 16 ? 18'(i) : 18'(32'h3FFEC + i);
    endfunction

    task automatic go(input logic [17:0] a, input logic w_n, input logic ad, input logic s_n,
            input logic [2:0] se, input logic [3:0] ln, input logic [35:0] d);
        logic acc;
        logic [17:0] ea;
        m_u.cycle(a, w_n, ad, s_n, se, ln, wpend, pdata, slp, ord, dn);
        @(negedge SYS_CLK);
        // outputs here answer the previous call, sampled at this call's launch edge
        chk(dq_oe, exp_oe && !dn);
        chk(dq_out, exp_dq);
        chk(write_room, 1'h1);
        if (!s_n) begin
            if (wpend) begin
                mem[paddr] = merge(mem[paddr], pdata, plns);
                wpend = 1'h0;
            end
            acc = 1'h0;
            if (!ad) begin
                bact = se == 3'h2 && !slp;
                acc = bact;
                if (bact) begin
                    base = a;
                    beat = 2'h0;
                    bw = !w_n;
                end
            end else if (bact) begin
                beat = beat + 2'h1;
                acc = 1'h1;
            end
            ea = {base[17:2], ord ? base[1:0] ^ beat : base[1:0] + beat};
            exp_oe = acc && !bw;
            if (acc && bw) begin
                wpend = 1'h1;
                paddr = ea;
                plns = ln;
                pdata = d;
            end else if (acc) begin
                exp_dq = mem[ea];
            end
        end
    endtask

    task automatic idle(input int n);
        repeat (n) go(18'h0, 1'h1, 1'h0, 1'h0, 3'h0, 4'hF, 36'h0);
    endtask

    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h60C9));
        repeat (12) @(posedge SYS_CLK);
        RST <= 1'h0;
        @(negedge SYS_CLK);
        chk(low_power, 1'h1);
        for (int i = 0; i < 20; i++) go(pa(i), 1'h0, 1'h0, 1'h0, 3'h2, 4'h0, rnd());
        go(pa(3), 1'h0, 1'h0, 1'h0, 3'h2, 4'h0, rnd());
        go(pa(3), 1'h1, 1'h0, 1'h0, 3'h2, 4'hF, 36'h0);
        go(pa(7), 1'h0, 1'h0, 1'h0, 3'h2, 4'h0, rnd());
        idle(1);
        go(pa(7), 1'h1, 1'h0, 1'h0, 3'h2, 4'h0, 36'h0);
        for (int l = 0; l < 4; l++) begin
            go(pa(8), 1'h0, 1'h0, 1'h0, 3'h2, ~(4'h1 << l), rnd());
            go(pa(8), 1'h1, 1'h0, 1'h0, 3'h2, 4'h0, 36'h0);
        end
        idle(4);
        chk(low_power, 1'h1);
        for (int o = 0; o < 2; o++) begin
            ord = o[0];
            idle(6);
            for (int s = 0; s < 4; s++) begin
                go(pa(16 + s), 1'h0, 1'h0, 1'h0, 3'h2, 4'h0, rnd());
                repeat (3) go(18'h0, 1'h0, 1'h1, 1'h0, 3'h2, 4'h0, rnd());
                go(pa(s), 1'h1, 1'h0, 1'h0, 3'h2, 4'hF, 36'h0);
                repeat (3) go(18'h0, 1'h0, 1'h1, 1'h0, 3'h2, 4'h0, 36'h0);
                chk(low_power, 1'h0);
                go(pa(16 + s), 1'h1, 1'h0, 1'h0, 3'h2, 4'hF, 36'h0);
                repeat (3) go(18'h0, 1'h1, 1'h1, 1'h0, 3'h2, 4'hF, 36'h0);
            end
        end
        // deselect mid burst, then a suspended edge inside a burst
        go(pa(0), 1'h1, 1'h0, 1'h0, 3'h2, 4'hF, 36'h0);
        go(18'h0, 1'h1, 1'h1, 1'h0, 3'h2, 4'hF, 36'h0);
        go(18'h0, 1'h1, 1'h0, 1'h0, 3'h6, 4'hF, 36'h0);
        go(18'h0, 1'h1, 1'h1, 1'h0, 3'h2, 4'hF, 36'h0);
        go(pa(4), 1'h1, 1'h0, 1'h0, 3'h2, 4'hF, 36'h0);
        go(pa(9), 1'h0, 1'h0, 1'h1, 3'h2, 4'h0, rnd());
        repeat (3) go(18'h0, 1'h1, 1'h1, 1'h0, 3'h2, 4'hF, 36'h0);
        slp = 1'h1;
        idle(6);
        chk(low_power, 1'h1);
        go(pa(1), 1'h1, 1'h0, 1'h0, 3'h2, 4'hF, 36'h0);
        slp = 1'h0;
        idle(6);
        repeat (400) begin
            dn = $urandom_range(9) == 0;
            go(pa($urandom_range(19)), 1'($urandom_range(1)), $urandom_range(2) == 0,
                $urandom_range(9) == 0, $urandom_range(7) < 5 ? 3'h2 : sels[$urandom_range(3)],
                4'($urandom_range(15)), rnd());
        end
        dn = 1'h0;
        idle(2);
        end_sim();
    end
endmodule
